// ===== include/gos_pkg.sv
package gos_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [6:0] GOS_IDX_PIN_DIRECTION     = 7'h08;
    localparam logic [6:0] GOS_IDX_PIN1_SOURCE       = 7'h53;
    localparam logic [6:0] GOS_IDX_MUTE_PIN_SOURCE   = 7'h54;
    localparam logic [6:0] GOS_IDX_PIN3_SOURCE       = 7'h55;
    localparam logic [6:0] GOS_IDX_OUTPUT_LEVEL      = 7'h56;
    localparam logic [6:0] GOS_IDX_POLARITY_INVERT   = 7'h57;
    localparam logic [6:0] GOS_IDX_PIN_STATUS        = 7'h5f;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int         GOS_SEL_W       = 4;
    localparam int         GOS_BIT_PIN1    = 3;
    localparam int         GOS_BIT_MUTE    = 4;
    localparam int         GOS_BIT_PIN3    = 5;
    localparam int         GOS_BIT_UV_HI   = 6;
    localparam int         GOS_BIT_UV_LO   = 7;
    localparam logic [7:0] GOS_PIN_MASK    = 8'h38;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] GOS_SEL_RESET   = 4'h0;
    localparam logic [7:0] GOS_BYTE_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // Selector codes
    // ------------------------------------------------------------------
    localparam logic [3:0] GOS_SRC_OFF       = 4'h0;
    localparam logic [3:0] GOS_SRC_DSP       = 4'h1;
    localparam logic [3:0] GOS_SRC_REGISTER  = 4'h2;
    localparam logic [3:0] GOS_SRC_AMUTE_LR  = 4'h3;
    localparam logic [3:0] GOS_SRC_AMUTE_L   = 4'h4;
    localparam logic [3:0] GOS_SRC_AMUTE_R   = 4'h5;
    localparam logic [3:0] GOS_SRC_CLK_BAD   = 4'h6;
    localparam logic [3:0] GOS_SRC_SDATA     = 4'h7;
    localparam logic [3:0] GOS_SRC_AMUTE_L_N = 4'h8;
    localparam logic [3:0] GOS_SRC_AMUTE_R_N = 4'h9;
    localparam logic [3:0] GOS_SRC_PLL_LOCK  = 4'ha;
    localparam logic [3:0] GOS_SRC_CP_CLK    = 4'hb;
    localparam logic [3:0] GOS_SRC_DAC_CLK   = 4'hc;
    localparam logic [3:0] GOS_SRC_DSP_DIV4  = 4'hd;
    localparam logic [3:0] GOS_SRC_UV_HI     = 4'he;
    localparam logic [3:0] GOS_SRC_UV_LO     = 4'hf;

    // Flags shared by all three pin multiplexers.
    typedef struct packed {
        logic amute_both;
        logic amute_l;
        logic amute_r;
        logic clk_invalid;
        logic sdata;
        logic amute_l_n;
        logic amute_r_n;
        logic pll_lock;
        logic cp_clk;
        logic dac_clk;
        logic dsp_div4;
        logic uv_hi;
        logic uv_lo;
    } gos_flags_t;

    // Per-pin controls taken from the register file and the pin's DSP output.
    typedef struct packed {
        logic [3:0] sel;
        logic       dsp_out;
        logic       level;
        logic       invert;
        logic       dir_out;
    } gos_pin_ctl_t;

endpackage

// ===== hw/gos_pin_mux.sv
`timescale 1ns/1ps
module gos_pin_mux
    import gos_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         full_set_i,
    input  wire gos_pin_ctl_t ctl_i,
    input  wire gos_flags_t   flags_i,
    output logic              pin_o,
    output logic              pin_oe_n_o
);

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    // The mute pin has no entries for codes 7 to 13, so they fall to low.
    function automatic logic pick(input logic [3:0] sel, input logic full,
                                  input gos_pin_ctl_t c, input gos_flags_t f);
        logic v;
        v = 1'b0;
        if (sel == GOS_SRC_OFF) begin
            v = 1'b0;
        end else if (sel == GOS_SRC_DSP) begin
            v = c.dsp_out;
        end else if (sel == GOS_SRC_REGISTER) begin
            v = c.level;
        end else if (sel == GOS_SRC_AMUTE_LR) begin
            v = f.amute_both;
        end else if (sel == GOS_SRC_AMUTE_L) begin
            v = f.amute_l;
        end else if (sel == GOS_SRC_AMUTE_R) begin
            v = f.amute_r;
        end else if (sel == GOS_SRC_CLK_BAD) begin
            v = f.clk_invalid;
        end else if (sel == GOS_SRC_UV_HI) begin
            v = f.uv_hi;
        end else if (sel == GOS_SRC_UV_LO) begin
            v = f.uv_lo;
        end else if (!full) begin
            v = 1'b0;
        end else if (sel == GOS_SRC_SDATA) begin
            v = f.sdata;
        end else if (sel == GOS_SRC_AMUTE_L_N) begin
            v = f.amute_l_n;
        end else if (sel == GOS_SRC_AMUTE_R_N) begin
            v = f.amute_r_n;
        end else if (sel == GOS_SRC_PLL_LOCK) begin
            v = f.pll_lock;
        end else if (sel == GOS_SRC_CP_CLK) begin
            v = f.cp_clk;
        end else if (sel == GOS_SRC_DAC_CLK) begin
            v = f.dac_clk;
        end else begin
            v = f.dsp_div4;
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------------
    // Inversion sits after the multiplexer, so it also flips the off level.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o      <= 1'b0;
            pin_oe_n_o <= 1'b1;
        end else begin
            pin_o      <= ctl_i.dir_out & (pick(ctl_i.sel, full_set_i, ctl_i, flags_i) ^ ctl_i.invert);
            pin_oe_n_o <= ~ctl_i.dir_out;
        end
    end

endmodule

// ===== hw/gos_output_select.sv
// Local design decision: the Wishbone register port.
`timescale 1ns/1ps
module gos_output_select
    import gos_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [8:0]  adr_i,
    input  wire logic [31:0] dat_i,
    input  wire logic        we_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic        dsp_pin1_i,
    input  wire logic        dsp_mute_i,
    input  wire logic        dsp_pin3_i,
    input  wire logic        amute_l_i,
    input  wire logic        amute_r_i,
    input  wire logic        clk_error_i,
    input  wire logic        clk_changing_i,
    input  wire logic        clk_missing_i,
    input  wire logic        serial_audio_data_out_i,
    input  wire logic        amute_l_n_i,
    input  wire logic        amute_r_n_i,
    input  wire logic        pll_lock_i,
    input  wire logic        cp_clk_i,
    input  wire logic        dac_clk_i,
    input  wire logic        uv_hi_i,
    input  wire logic        uv_lo_i,
    output logic             general_pin_one_o,
    output logic             general_pin_one_oe_n_o,
    output logic             mute_pin_o,
    output logic             mute_pin_oe_n_o,
    output logic             general_pin_three_o,
    output logic             general_pin_three_oe_n_o
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [3:0]   pin1_source_select_r;
    logic [3:0]   mute_pin_source_select_r;
    logic [3:0]   pin3_source_select_r;
    logic [7:0]   pin_direction_r;
    logic [7:0]   register_output_level_r;
    logic [7:0]   output_polarity_invert_r;
    logic         ack_r;
    logic [31:0]  dat_r;
    logic [31:0]  dat_nxt;
    logic         wr_now;
    logic [6:0]   reg_idx;
    logic [2:0]   uv_hi_sync_r;
    logic [2:0]   uv_lo_sync_r;
    logic         uv_hi_r;
    logic         uv_lo_r;
    logic [1:0]   dsp_div_r;
    gos_flags_t   flags_r;
    gos_flags_t   flags_nxt;
    gos_pin_ctl_t ctl_pin1;
    gos_pin_ctl_t ctl_mute;
    gos_pin_ctl_t ctl_pin3;

    // ------------------------------------------------------------------
    // Bus decode helpers
    // ------------------------------------------------------------------
    // Registers are byte wide and live in lane zero of each word.
    function automatic logic hit(input logic [6:0] idx, input logic [6:0] want);
        return idx == want;
    endfunction

    // Writes to the selectors keep only the low nibble.
    function automatic logic [3:0] sel_field(input logic [31:0] d);
        return d[3:0];
    endfunction

    assign reg_idx = adr_i[8:2];

    // A write lands on the edge at which the master sees ack high.
    assign wr_now = cyc_i & stb_i & we_i & ack_r & sel_i[0];

    // ------------------------------------------------------------------
    // Wishbone handshake
    // ------------------------------------------------------------------
    // One wait state: ack rises one cycle after the strobe and drops the
    // next cycle, so a held strobe gets a second ack two cycles after the first.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= cyc_i & stb_i & ~ack_r;
        end
    end

    // Read data is captured with the strobe and held through the ack cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (cyc_i & stb_i & ~ack_r) begin
            dat_r <= dat_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    // Reserved and unmapped bits read as zero.
    always_comb begin
        dat_nxt = 32'h0000_0000;
        if (hit(reg_idx, GOS_IDX_PIN1_SOURCE)) begin
            dat_nxt[3:0] = pin1_source_select_r;
        end else if (hit(reg_idx, GOS_IDX_MUTE_PIN_SOURCE)) begin
            dat_nxt[3:0] = mute_pin_source_select_r;
        end else if (hit(reg_idx, GOS_IDX_PIN3_SOURCE)) begin
            dat_nxt[3:0] = pin3_source_select_r;
        end else if (hit(reg_idx, GOS_IDX_PIN_DIRECTION)) begin
            dat_nxt[7:0] = pin_direction_r;
        end else if (hit(reg_idx, GOS_IDX_OUTPUT_LEVEL)) begin
            dat_nxt[7:0] = register_output_level_r;
        end else if (hit(reg_idx, GOS_IDX_POLARITY_INVERT)) begin
            dat_nxt[7:0] = output_polarity_invert_r;
        end else if (hit(reg_idx, GOS_IDX_PIN_STATUS)) begin
            dat_nxt[GOS_BIT_PIN1]  = general_pin_one_o;
            dat_nxt[GOS_BIT_MUTE]  = mute_pin_o;
            dat_nxt[GOS_BIT_PIN3]  = general_pin_three_o;
            dat_nxt[GOS_BIT_UV_HI] = uv_hi_r;
            dat_nxt[GOS_BIT_UV_LO] = uv_lo_r;
        end else begin
            dat_nxt = 32'h0000_0000;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ------------------------------------------------------------------
    // Source selector registers
    // ------------------------------------------------------------------
    // The upper nibble is not stored; it reads back as zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin1_source_select_r <= GOS_SEL_RESET;
        end else if (wr_now && hit(reg_idx, GOS_IDX_PIN1_SOURCE)) begin
            pin1_source_select_r <= sel_field(dat_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mute_pin_source_select_r <= GOS_SEL_RESET;
        end else if (wr_now && hit(reg_idx, GOS_IDX_MUTE_PIN_SOURCE)) begin
            mute_pin_source_select_r <= sel_field(dat_i);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin3_source_select_r <= GOS_SEL_RESET;
        end else if (wr_now && hit(reg_idx, GOS_IDX_PIN3_SOURCE)) begin
            pin3_source_select_r <= sel_field(dat_i);
        end
    end

    // ------------------------------------------------------------------
    // Direction, level and polarity registers
    // ------------------------------------------------------------------
    // Only the three pin bits exist; the other bits are reserved.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_direction_r <= GOS_BYTE_RESET;
        end else if (wr_now && hit(reg_idx, GOS_IDX_PIN_DIRECTION)) begin
            pin_direction_r <= dat_i[7:0] & GOS_PIN_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            register_output_level_r <= GOS_BYTE_RESET;
        end else if (wr_now && hit(reg_idx, GOS_IDX_OUTPUT_LEVEL)) begin
            register_output_level_r <= dat_i[7:0] & GOS_PIN_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            output_polarity_invert_r <= GOS_BYTE_RESET;
        end else if (wr_now && hit(reg_idx, GOS_IDX_POLARITY_INVERT)) begin
            output_polarity_invert_r <= dat_i[7:0] & GOS_PIN_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Undervoltage comparator synchronisers
    // ------------------------------------------------------------------
    // The comparators are analog and asynchronous. The first stage feeds
    // only the second; a new level is accepted once stages two and three
    // agree, which filters a single-cycle glitch at the cost of latency.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_hi_sync_r <= 3'h0;
            uv_lo_sync_r <= 3'h0;
        end else begin
            uv_hi_sync_r <= {uv_hi_sync_r[1:0], uv_hi_i};
            uv_lo_sync_r <= {uv_lo_sync_r[1:0], uv_lo_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            uv_hi_r <= 1'b0;
            uv_lo_r <= 1'b0;
        end else begin
            if (uv_hi_sync_r[1] == uv_hi_sync_r[2]) begin
                uv_hi_r <= uv_hi_sync_r[2];
            end
            if (uv_lo_sync_r[1] == uv_lo_sync_r[2]) begin
                uv_lo_r <= uv_lo_sync_r[2];
            end
        end
    end

    // ------------------------------------------------------------------
    // DSP clock divider
    // ------------------------------------------------------------------
    // The DSP runs on this block's clock, so a free two-bit counter gives
    // the divide-by-four square wave; its top bit toggles every 2 cycles.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dsp_div_r <= 2'h0;
        end else begin
            dsp_div_r <= dsp_div_r + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Shared flag bundle
    // ------------------------------------------------------------------
    // Combined flags are formed once here rather than in each pin mux.
    always_comb begin
        flags_nxt             = '0;
        flags_nxt.amute_both  = amute_l_i & amute_r_i;
        flags_nxt.amute_l     = amute_l_i;
        flags_nxt.amute_r     = amute_r_i;
        flags_nxt.clk_invalid = clk_error_i | clk_changing_i | clk_missing_i;
        flags_nxt.sdata       = serial_audio_data_out_i;
        flags_nxt.amute_l_n   = amute_l_n_i;
        flags_nxt.amute_r_n   = amute_r_n_i;
        flags_nxt.pll_lock    = pll_lock_i;
        flags_nxt.cp_clk      = cp_clk_i;
        flags_nxt.dac_clk     = dac_clk_i;
        flags_nxt.dsp_div4    = dsp_div_r[1];
        flags_nxt.uv_hi       = uv_hi_r;
        flags_nxt.uv_lo       = uv_lo_r;
    end

    // Registering the bundle keeps the pin path one gate deep; the
    // forwarded clocks reach the pins two cycles after their sources.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Per-pin control bundles
    // ------------------------------------------------------------------
    always_comb begin
        ctl_pin1.sel     = pin1_source_select_r;
        ctl_pin1.dsp_out = dsp_pin1_i;
        ctl_pin1.level   = register_output_level_r[GOS_BIT_PIN1];
        ctl_pin1.invert  = output_polarity_invert_r[GOS_BIT_PIN1];
        ctl_pin1.dir_out = pin_direction_r[GOS_BIT_PIN1];
        ctl_mute.sel     = mute_pin_source_select_r;
        ctl_mute.dsp_out = dsp_mute_i;
        ctl_mute.level   = register_output_level_r[GOS_BIT_MUTE];
        ctl_mute.invert  = output_polarity_invert_r[GOS_BIT_MUTE];
        ctl_mute.dir_out = pin_direction_r[GOS_BIT_MUTE];
        ctl_pin3.sel     = pin3_source_select_r;
        ctl_pin3.dsp_out = dsp_pin3_i;
        ctl_pin3.level   = register_output_level_r[GOS_BIT_PIN3];
        ctl_pin3.invert  = output_polarity_invert_r[GOS_BIT_PIN3];
        ctl_pin3.dir_out = pin_direction_r[GOS_BIT_PIN3];
    end

    // ------------------------------------------------------------------
    // Pin multiplexers
    // ------------------------------------------------------------------
    // Pins one and three carry the full source list.
    gos_pin_mux u_pin1 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .full_set_i (1'b1),
        .ctl_i      (ctl_pin1),
        .flags_i    (flags_r),
        .pin_o      (general_pin_one_o),
        .pin_oe_n_o (general_pin_one_oe_n_o)
    );

    // The mute pin lacks codes 7 to 13; its mux gives low for them before inversion.
    gos_pin_mux u_mute (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .full_set_i (1'b0),
        .ctl_i      (ctl_mute),
        .flags_i    (flags_r),
        .pin_o      (mute_pin_o),
        .pin_oe_n_o (mute_pin_oe_n_o)
    );

    gos_pin_mux u_pin3 (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .full_set_i (1'b1),
        .ctl_i      (ctl_pin3),
        .flags_i    (flags_r),
        .pin_o      (general_pin_three_o),
        .pin_oe_n_o (general_pin_three_oe_n_o)
    );

endmodule

// ===== tb/gos_pin_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// Board side of the three pins
// ----------------------------------------
module gos_pin_monitor (
    input  wire logic [2:0] pin_i,
    input  wire logic [2:0] oe_n_i,
    output logic      [2:0] line_o
);
    // Pull-downs hold a released pin low, so a stale level can never pass for a driven one.
    assign line_o = pin_i & ~oe_n_i;
endmodule

// ===== tb/gos_sel_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module gos_sel_chk (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        general_pin_one_o,
    input wire logic        general_pin_one_oe_n_o,
    input wire logic        mute_pin_o,
    input wire logic        mute_pin_oe_n_o,
    input wire logic        general_pin_three_o,
    input wire logic        general_pin_three_oe_n_o
);
    // All checks share the one clock; the reset check overrides the disable.
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
    a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held too long");
    a_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("ack without request");
    a_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper read bits set");
    a_pin1_released: assert property (general_pin_one_oe_n_o |-> !general_pin_one_o) else $error("pin one");
    a_mute_released: assert property (mute_pin_oe_n_o |-> !mute_pin_o) else $error("mute pin");
    a_pin3_released: assert property (general_pin_three_oe_n_o |-> !general_pin_three_o) else $error("pin3");
    a_reset_idle: assert property (disable iff (1'b0) rst_i |=> !ack_o && dat_o == 32'h0 &&
        general_pin_one_oe_n_o && mute_pin_oe_n_o && general_pin_three_oe_n_o) else $error("reset state");
endmodule
bind gos_output_select gos_sel_chk gos_sel_chk_inst (.clk_i, .rst_i, .cyc_i, .stb_i, .dat_o, .ack_o,
    .general_pin_one_o, .general_pin_one_oe_n_o, .mute_pin_o, .mute_pin_oe_n_o, .general_pin_three_o,
    .general_pin_three_oe_n_o);

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import gos_pkg::*; ();
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [8:0]  adr_i = 9'h000;
    logic [31:0] dat_i = 32'h0;
    logic [3:0]  sel_i = 4'h0;
    logic [15:0] src = 16'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    wire  [2:0]  pin, oe_n, line;
    logic [15:0] pat [3] = '{16'h0000, 16'hffff, 16'h6a59};
    int          mismatches = 0, compares = 0, cycles = 0;
    always #12.5 clk_i = ~clk_i;
    gos_output_select gos_output_select_inst (.clk_i, .rst_i, .adr_i, .dat_i, .we_i, .sel_i, .cyc_i, .stb_i,
        .dat_o, .ack_o, .dsp_pin1_i(src[0]), .dsp_mute_i(src[1]), .dsp_pin3_i(src[2]), .amute_l_i(src[3]),
        .amute_r_i(src[4]), .clk_error_i(src[5]), .clk_changing_i(src[6]), .clk_missing_i(src[7]),
        .serial_audio_data_out_i(src[8]), .amute_l_n_i(src[9]), .amute_r_n_i(src[10]), .pll_lock_i(src[11]),
        .cp_clk_i(src[12]), .dac_clk_i(src[13]), .uv_hi_i(src[14]), .uv_lo_i(src[15]),
        .general_pin_one_o(pin[0]), .general_pin_one_oe_n_o(oe_n[0]), .mute_pin_o(pin[1]),
        .mute_pin_oe_n_o(oe_n[1]), .general_pin_three_o(pin[2]), .general_pin_three_oe_n_o(oe_n[2]));
    gos_pin_monitor gos_pin_monitor_inst (.pin_i(pin), .oe_n_i(oe_n), .line_o(line));
    // One bus cycle; ack and read data are taken at the rising edge, and the request drops right after it.
    task wb(input logic w, input logic [6:0] i, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i} <= {2'b11, w, 4'hf};
        adr_i <= {i, 2'b00};
        dat_i <= {24'h0, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // The flag paths need up to six edges, so eight covers every source.
    task settle;
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    function automatic logic expv(int p, logic [3:0] c, logic [15:0] s);
        case (c)
            4'h0: return 1'b0;
            4'h1: return s[p];
            4'h2: return p != 1;
            4'h3: return s[3] & s[4];
            4'h4, 4'h5: return s[c - 1];
            4'h6: return |s[7:5];
            4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc: return (p == 1) ? 1'b0 : s[c + 1];
            4'hd: return (p == 1) ? 1'b0 : cycles[1]; // The divider starts at reset and the pin trails it by two edges.
            default: return s[c];
        endcase
    endfunction
    task t_regs;
        logic [31:0] q;
        for (int i = 0; i < 3; i++) begin
            wb(1'b0, GOS_IDX_PIN1_SOURCE + 7'(i), 8'h00, q);
            chk(q, 32'h0);
            wb(1'b1, GOS_IDX_PIN1_SOURCE + 7'(i), 8'h0f, q);
            wb(1'b0, GOS_IDX_PIN1_SOURCE + 7'(i), 8'h00, q);
            chk(q, 32'h0f);
        end
        wb(1'b0, 7'h60, 8'h00, q);
        chk(q, 32'h0);
        $display("t_regs done");
    endtask
    task t_dir;
        logic [31:0] q;
        for (int i = 0; i < 3; i++) wb(1'b1, GOS_IDX_PIN1_SOURCE + 7'(i), 8'h02, q);
        wb(1'b1, GOS_IDX_OUTPUT_LEVEL, 8'h28, q);
        settle;
        chk({26'h0, oe_n, line}, 32'h38);
        wb(1'b1, GOS_IDX_PIN_DIRECTION, 8'h38, q);
        settle;
        chk({26'h0, oe_n, line}, 32'h05);
        $display("t_dir done");
    endtask
    task t_codes;
        logic [31:0] q;
        logic [31:0] e;
        for (int v = 0; v < 2; v++) begin
            wb(1'b1, GOS_IDX_POLARITY_INVERT, v ? 8'h38 : 8'h00, q);
            for (int k = 0; k < 3; k++) begin
                src <= pat[k];
                for (int c = 0; c < 16; c++) begin
                    for (int i = 0; i < 3; i++) wb(1'b1, GOS_IDX_PIN1_SOURCE + 7'(i), 8'(c), q);
                    settle;
                    e = 32'({expv(2, 4'(c), src), expv(1, 4'(c), src), expv(0, 4'(c), src)} ^ {3{v[0]}});
                    chk(32'(line), e);
                end
            end
        end
        $display("t_codes done");
    endtask
    task results;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // A hung handshake ends here as a counted mismatch.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results;
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_dir;
        t_codes;
        results;
    end
endmodule
